// ---- include/crb_pkg.sv ----
// Constants and carrier types for the conversion result register bank
package crb_pkg;

  // ==========================================================================
  // Widths
  localparam int RES_W  = 10;
  localparam int ADDR_W = 8;
  localparam int REG_W  = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_LO_FIRST  = 8'h04;
  localparam logic [7:0] ADDR_LO_UPPER  = 8'h05;
  localparam logic [7:0] ADDR_SUPPLY_HI = 8'h06;
  localparam logic [7:0] ADDR_ONCHIP_HI = 8'h07;
  localparam logic [7:0] ADDR_FIRST_HI  = 8'h08;
  localparam logic [7:0] ADDR_IN2_HI    = 8'h09;
  localparam logic [7:0] ADDR_IN3_HI    = 8'h0a;
  localparam logic [7:0] ADDR_IN4_HI    = 8'h0b;
  localparam logic [7:0] ADDR_IN5_HI    = 8'h0c;
  localparam logic [7:0] ADDR_IN8_HI    = 8'h0f;

  // ==========================================================================
  // Field positions and reset values
  localparam int         HI_MSB_POS  = 9;
  localparam int         HI_LSB_POS  = 2;
  localparam int         SLICE_W     = 2;
  localparam logic [7:0] LO_RST      = 8'h00;
  localparam logic [7:0] HI_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ==========================================================================
  // Input-pair select codes
  localparam logic [1:0] SEL_INPUTS = 2'h0;
  localparam logic [1:0] SEL_REMOTE = 2'h2;

  // ==========================================================================
  // Carriers
  typedef enum logic [3:0] {
    CH_REMOTE = 4'h0,
    CH_IN1    = 4'h1,
    CH_IN2    = 4'h2,
    CH_IN3    = 4'h3,
    CH_IN4    = 4'h4,
    CH_IN5    = 4'h5,
    CH_IN6    = 4'h6,
    CH_IN7    = 4'h7,
    CH_IN8    = 4'h8,
    CH_SUPPLY = 4'h9,
    CH_ONCHIP = 4'ha
  } crb_chan_type;

  typedef struct packed {
    crb_chan_type     chan;
    logic [RES_W-1:0] data;
  } crb_result_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rdEn;
    logic              wrEn;
    logic [REG_W-1:0]  wrData;
  } crb_req_type;

endpackage : crb_pkg

// ---- rtl/crb_result_bank.sv ----
// Read-only bank of conversion result registers
`timescale 1ns/1ps

// Notes on behaviour
// - Register 04h holds low slices: inputs two to four in D2..D7, first slot in D0..D1.
// - First slot low bits come from the remote sensor or input one per the pair select.
// - Register 05h holds the low slices of inputs five to eight in ascending order from D0.
// - In each slice result bit 0 sits in the even position and bit 1 in the odd one above.
// - Register 06h holds the supply reading's upper bits, loaded with a measurement.
// - Register 07h holds the upper bits of the twos complement on-chip temperature.
// - Register 08h holds the upper bits of the remote temperature or of input one.
// - Register 09h holds input two's upper bits, completed by D2..D3 of 04h.
// - Register 0Ah holds input three's upper bits, completed by D4..D5 of 04h.
// - Register 0Bh holds input four's upper bits, completed by D6..D7 of 04h.
// - Register 0Ch holds input five's upper bits, completed by D0..D1 of 05h.
// - Upper-bit registers of inputs five to eight sit at 0Ch through 0Fh.
// - Every register of the bank but the supply one clears to zero at reset.
// - Select code 00 picks input one, 10 the remote sensor; input two is stored under every code; 01 and 11 are not used.
module crb_result_bank #(
  parameter int RES_W = crb_pkg::RES_W
) (
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire logic                         resultValid,
  input  wire crb_pkg::crb_result_type      result,
  input  wire logic [1:0]                   inputPairSelect,
  input  wire logic [crb_pkg::RES_W-1:0]    supplyInit,
  input  wire crb_pkg::crb_req_type         req,
  output logic [crb_pkg::REG_W-1:0]         regRdData_r,
  output logic                              regRdValid_r,
  output logic                              firstSlotRemote_r
);

  // ==========================================================================
  // Elaboration check
  if (RES_W != crb_pkg::RES_W)
  begin : g_bad_width
    $error("crb_result_bank serves only the ten-bit result width");
  end

  // ==========================================================================
  // Storage
  localparam int HI_N = 10;

  logic [crb_pkg::REG_W-1:0] loFirst_r;
  logic [crb_pkg::REG_W-1:0] loUpper_r;
  logic [crb_pkg::REG_W-1:0] hiReg_r [HI_N];
  logic [crb_pkg::REG_W-1:0] supplyHi_r;

  logic       selRemote;
  logic       selInputs;
  logic       firstHit;
  logic       loFirstHit;
  logic       loUpperHit;
  logic [1:0] slicePos;
  logic       hiHit;
  logic [3:0] hiIdx;
  logic [crb_pkg::REG_W-1:0] hiByte;
  logic [1:0] loBits;

  // ==========================================================================
  // Result decode
  assign selRemote = (inputPairSelect == crb_pkg::SEL_REMOTE);
  assign selInputs = (inputPairSelect == crb_pkg::SEL_INPUTS);
  // Undefined select codes freeze the first slot instead of guessing a source
  assign firstHit  = resultValid
                   && ((result.chan == crb_pkg::CH_REMOTE && selRemote)
                    || (result.chan == crb_pkg::CH_IN1 && selInputs));
  assign hiByte    = result.data[crb_pkg::HI_MSB_POS:crb_pkg::HI_LSB_POS];
  assign loBits    = result.data[crb_pkg::SLICE_W-1:0];

  always_comb
  begin
    loFirstHit = 1'b0;
    loUpperHit = 1'b0;
    slicePos   = 2'h0;
    hiHit      = 1'b0;
    hiIdx      = 4'h0;
    unique case (result.chan)
      crb_pkg::CH_REMOTE, crb_pkg::CH_IN1:
      begin
        loFirstHit = firstHit;
        slicePos   = 2'h0;
        hiHit      = firstHit;
        hiIdx      = 4'h2;
      end
      crb_pkg::CH_IN2, crb_pkg::CH_IN3, crb_pkg::CH_IN4:
      begin
        loFirstHit = resultValid;
        slicePos   = 2'(result.chan - crb_pkg::CH_IN1);
        hiHit      = resultValid;
        hiIdx      = 4'(result.chan + 4'h1);
      end
      crb_pkg::CH_IN5, crb_pkg::CH_IN6, crb_pkg::CH_IN7, crb_pkg::CH_IN8:
      begin
        loUpperHit = resultValid;
        slicePos   = 2'(result.chan - crb_pkg::CH_IN5);
        hiHit      = resultValid;
        hiIdx      = 4'(result.chan + 4'h1);
      end
      crb_pkg::CH_ONCHIP:
      begin
        hiHit = resultValid;
        hiIdx = 4'h1;
      end
      default:
      begin
        hiHit = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Low-slice registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      loFirst_r <= crb_pkg::LO_RST;
    end
    else if (loFirstHit)
    begin
      loFirst_r[2*slicePos +: 2] <= loBits;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      loUpper_r <= crb_pkg::LO_RST;
    end
    else if (loUpperHit)
    begin
      loUpper_r[2*slicePos +: 2] <= loBits;
    end
  end

  // ==========================================================================
  // Upper-bit registers; slot 0 of the array is unused, supply has its own
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < HI_N; i++)
      begin
        hiReg_r[i] <= crb_pkg::HI_RST;
      end
    end
    else if (hiHit)
    begin
      hiReg_r[hiIdx] <= hiByte;
    end
  end

  // Held in reset with a live measurement so it never reads a cleared value
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      supplyHi_r <= supplyInit[crb_pkg::HI_MSB_POS:crb_pkg::HI_LSB_POS];
    end
    else if (resultValid && result.chan == crb_pkg::CH_SUPPLY)
    begin
      supplyHi_r <= hiByte;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      firstSlotRemote_r <= 1'b0;
    end
    else if (firstHit)
    begin
      firstSlotRemote_r <= (result.chan == crb_pkg::CH_REMOTE);
    end
  end

  // ==========================================================================
  // Register read port; writes are accepted and dropped
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      regRdData_r  <= crb_pkg::UNMAPPED_RD;
      regRdValid_r <= 1'b0;
    end
    else
    begin
      regRdValid_r <= req.rdEn;
      if (req.rdEn)
      begin
        if (req.addr == crb_pkg::ADDR_LO_FIRST)
          regRdData_r <= loFirst_r;
        else if (req.addr == crb_pkg::ADDR_LO_UPPER)
          regRdData_r <= loUpper_r;
        else if (req.addr == crb_pkg::ADDR_SUPPLY_HI)
          regRdData_r <= supplyHi_r;
        else if (req.addr >= crb_pkg::ADDR_ONCHIP_HI && req.addr <= crb_pkg::ADDR_IN8_HI)
          regRdData_r <= hiReg_r[4'(req.addr - crb_pkg::ADDR_SUPPLY_HI)];
        else
          regRdData_r <= crb_pkg::UNMAPPED_RD;
      end
    end
  end
  // Write strobe has no path into any storage above

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_first_low_sel: assert property (
    firstHit |=> loFirst_r[1:0] == $past(loBits))
    else $error("first slot low bits not taken from selected source");

  a_first_ignored: assert property (
    resultValid && result.chan == crb_pkg::CH_REMOTE && !selRemote
      |=> $stable(loFirst_r) && $stable(hiReg_r[2]))
    else $error("unselected remote result changed first slot");

  a_in2_slice: assert property (
    resultValid && result.chan == crb_pkg::CH_IN2
      |=> loFirst_r[3:2] == $past(result.data[1:0]) && hiReg_r[3] == $past(result.data[9:2]))
    else $error("input two bits misplaced");

  a_in3_slice: assert property (
    resultValid && result.chan == crb_pkg::CH_IN3
      |=> loFirst_r[5:4] == $past(result.data[1:0]) && hiReg_r[4] == $past(result.data[9:2]))
    else $error("input three bits misplaced");

  a_in4_slice: assert property (
    resultValid && result.chan == crb_pkg::CH_IN4 |=> loFirst_r[7:6] == $past(result.data[1:0]))
    else $error("input four low slice misplaced");

  a_in5_slice: assert property (
    resultValid && result.chan == crb_pkg::CH_IN5
      |=> loUpper_r[1:0] == $past(result.data[1:0]) && hiReg_r[6] == $past(result.data[9:2]))
    else $error("input five bits misplaced");

  a_in6_slice: assert property (
    resultValid && result.chan == crb_pkg::CH_IN6
      |=> loUpper_r[3:2] == $past(result.data[1:0]) && hiReg_r[7] == $past(result.data[9:2]))
    else $error("input six bits misplaced");

  a_in8_slice: assert property (
    resultValid && result.chan == crb_pkg::CH_IN8 |=> loUpper_r[7:6] == $past(result.data[1:0]))
    else $error("input eight low slice misplaced");

  a_in8_read: assert property (
    resultValid && result.chan == crb_pkg::CH_IN8 ##1 !resultValid ##1
      (req.rdEn && req.addr == crb_pkg::ADDR_IN8_HI && !resultValid)
      |=> regRdValid_r && regRdData_r == $past(result.data[9:2], 3))
    else $error("input eight upper byte not read at 0Fh");

  a_onchip_read: assert property (
    resultValid && result.chan == crb_pkg::CH_ONCHIP ##1 !resultValid ##1
      (req.rdEn && req.addr == crb_pkg::ADDR_ONCHIP_HI && !resultValid)
      |=> regRdData_r == $past(result.data[9:2], 3))
    else $error("on-chip temperature not read at 07h");

  a_supply_load: assert property (
    resultValid && result.chan == crb_pkg::CH_SUPPLY |=> supplyHi_r == $past(hiByte))
    else $error("supply upper byte not loaded");

  a_write_ignored: assert property (
    req.wrEn && !resultValid |=> $stable(loFirst_r) && $stable(loUpper_r) && $stable(supplyHi_r))
    else $error("write altered a result register");

  a_reset_clear: assert property (
    disable iff (1'b0) !rstn |=> loFirst_r == crb_pkg::LO_RST && loUpper_r == crb_pkg::LO_RST
      && hiReg_r[2] == crb_pkg::HI_RST)
    else $error("result register not cleared by reset");

  a_first_hi: assert property (
    firstHit |=> hiReg_r[2] == $past(result.data[9:2]))
    else $error("first slot upper byte not stored");

  a_in1_ignored: assert property (
    resultValid && result.chan == crb_pkg::CH_IN1 && !selInputs
      |=> $stable(loFirst_r) && $stable(hiReg_r[2]))
    else $error("unselected input one result changed first slot");

  a_unmapped_read: assert property (
    req.rdEn && (req.addr < crb_pkg::ADDR_LO_FIRST || req.addr > crb_pkg::ADDR_IN8_HI)
      |=> regRdData_r == crb_pkg::UNMAPPED_RD)
    else $error("unmapped address did not read zero");

  a_read_valid: assert property (
    req.rdEn |=> regRdValid_r)
    else $error("read answer missing");

  a_read_drop: assert property (
    !req.rdEn |=> !regRdValid_r)
    else $error("read answer without a read");

  c_remote_slot: cover property (firstHit && result.chan == crb_pkg::CH_REMOTE);
  c_input_one:   cover property (firstHit && result.chan == crb_pkg::CH_IN1);
  c_read_low:    cover property (req.rdEn && req.addr == crb_pkg::ADDR_LO_UPPER);
  c_write_try:   cover property (req.wrEn && req.addr == crb_pkg::ADDR_FIRST_HI);
  c_undef_sel:   cover property (resultValid && inputPairSelect[0]);

endmodule : crb_result_bank

// ---- test/crb_host_model.sv ----
// Host model driving the register request port and the pair select
`timescale 1ns/1ps
// ==========================================================================
// Host side
module crb_host_model (
  input  wire logic            core_clk,
  output crb_pkg::crb_req_type req,
  output logic [1:0]           inputPairSelect,
  input  wire logic [7:0]      regRdData_r,
  input  wire logic            regRdValid_r
);
  initial
  begin
    req = '0;
    inputPairSelect = crb_pkg::SEL_INPUTS;
  end

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk);
    req.addr = a;
    req.rdEn = 1'b1;
    @(negedge core_clk);
    d = regRdData_r;
    v = regRdValid_r;
    req.rdEn = 1'b0;
    // Released address flips so a stale value cannot pass
    req.addr = ~a;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req.addr = a;
    req.wrData = d;
    req.wrEn = 1'b1;
    @(negedge core_clk);
    req.wrEn = 1'b0;
    req.addr = ~a;
    req.wrData = ~d;
  endtask : wr

  // Undefined codes only when the bench asks for them
  task automatic sel(input logic [1:0] c);
    @(negedge core_clk);
    inputPairSelect = c;
  endtask : sel
endmodule : crb_host_model

// ---- test/testbench.sv ----
// Self-checking bench for the conversion result register bank
`timescale 1ns/1ps
module testbench;
  logic                   core_clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   resultValid = 1'b0;
  crb_pkg::crb_result_type result = '0;
  logic [1:0]             inputPairSelect;
  logic [9:0]             supplyInit = 10'h000;
  crb_pkg::crb_req_type   req;
  logic [7:0]             regRdData_r;
  logic                   regRdValid_r;
  logic                   firstSlotRemote_r;
  int                     error_cnt = 0;
  int                     n_compared = 0;
  int                     seed = 32'ha2f2;
  logic [7:0]             expReg [0:15];
  logic                   expRemote;

  always #4 core_clk = ~core_clk;

  crb_host_model host (.core_clk(core_clk), .req(req), .inputPairSelect(inputPairSelect),
    .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r));
  crb_result_bank uut (.core_clk(core_clk), .rstn(rstn), .resultValid(resultValid),
    .result(result), .inputPairSelect(inputPairSelect), .supplyInit(supplyInit), .req(req),
    .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r),
    .firstSlotRemote_r(firstSlotRemote_r));

  // ==========================================================================
  // Expectation and checks
  function automatic void apply(input logic [3:0] ch, input logic [9:0] d, input logic [1:0] s);
    int hi;
    int lo;
    int pos;
    hi = -1;
    lo = -1;
    pos = 0;
    if (ch <= 4'h1)
    begin
      if ((ch == 4'h0 && s == crb_pkg::SEL_REMOTE) || (ch == 4'h1 && s == crb_pkg::SEL_INPUTS))
      begin
        hi = 8;
        lo = 4;
        expRemote = (ch == 4'h0);
      end
    end
    else if (ch <= 4'h8)
    begin
      hi = ch + 7;
      lo = (ch <= 4'h4) ? 4 : 5;
      pos = (ch <= 4'h4) ? 2 * (ch - 1) : 2 * (ch - 5);
    end
    else
      hi = (ch == 4'h9) ? 6 : 7;
    if (hi >= 0)
      expReg[hi] = d[9:2];
    if (lo >= 0)
      expReg[lo][pos +: 2] = d[1:0];
  endfunction : apply

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input int a);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: addr %h got %h expected %h", $time, a, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk({7'h00, v}, 8'h01, a);
    chk(d, exp, a);
    @(negedge core_clk);
    chk({7'h00, regRdValid_r}, 8'h00, a);
  endtask : rdchk

  task automatic check_all();
    for (int a = 0; a < 16; a++)
      rdchk(a[7:0], expReg[a]);
    rdchk(8'h10, crb_pkg::UNMAPPED_RD);
    rdchk(8'hff, crb_pkg::UNMAPPED_RD);
    chk({7'h00, firstSlotRemote_r}, {7'h00, expRemote}, 8);
  endtask : check_all

  task automatic put(input logic [3:0] ch, input logic [9:0] d);
    @(negedge core_clk);
    resultValid = 1'b1;
    result.chan = crb_pkg::crb_chan_type'(ch);
    result.data = d;
    @(negedge core_clk);
    resultValid = 1'b0;
    result.data = ~d;
    apply(ch, d, inputPairSelect);
  endtask : put

  task automatic do_reset();
    @(negedge core_clk);
    rstn = 1'b0;
    supplyInit = 10'($random(seed));
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    chk(regRdData_r, crb_pkg::UNMAPPED_RD, 0);
    chk({7'h00, regRdValid_r}, 8'h00, 0);
    for (int i = 0; i < 16; i++)
      expReg[i] = crb_pkg::HI_RST;
    expReg[6] = supplyInit[9:2];
    expRemote = 1'b0;
  endtask : do_reset

  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end

  initial
  begin
    do_reset();
    check_all();
    // Undefined codes must leave the first slot frozen
    for (int k = 0; k < 4; k++)
    begin
      host.sel(k[1:0]);
      for (int ch = 0; ch < 11; ch++)
        put(ch[3:0], (k == 0) ? 10'h201 : 10'($random(seed)));
      check_all();
    end
    host.sel(crb_pkg::SEL_REMOTE);
    put(4'h0, 10'h3fe);
    rdchk(8'h08, 8'hff);
    put(4'h8, 10'($random(seed)));
    rdchk(8'h0f, expReg[15]);
    put(4'ha, 10'h200);
    rdchk(8'h07, 8'h80);
    for (int a = 0; a < 16; a++)
      host.wr(a[7:0], ~expReg[a]);
    check_all();
    do_reset();
    check_all();
    close_out();
  end
endmodule : testbench
